// ==== inc/tfs_pkg.sv ====
// Purpose: Constants and helpers for the thermal and fan setup registers
// Assumes: 10 MHz core clock, byte-wide register port
// Notes: Filtered-temperature offsets sit in a spare corner of the map
package tfs_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_THRESH = 8'hBE;
    localparam logic [7:0] ADDR_RAMP = 8'hBF;
    localparam logic [7:0] ADDR_HYST_A = 8'hC0;
    localparam logic [7:0] ADDR_HYST_B = 8'hC1;
    localparam logic [7:0] ADDR_SMOOTH = 8'hC2;
    localparam logic [7:0] ADDR_FILT_ONE = 8'hF8;
    localparam logic [7:0] ADDR_FILT_TWO = 8'hF9;

    // Reset values and writable bits
    localparam logic [7:0] RST_THRESH = 8'h00;
    localparam logic [7:0] RST_RAMP = 8'h00;
    localparam logic [7:0] RST_HYST = 8'h44;
    localparam logic [7:0] RST_SMOOTH = 8'h00;
    localparam logic [7:0] THRESH_WR_MASK = 8'hF3;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Field positions
    localparam int RAMP_REG_LSB = 0;
    localparam int RAMP_CPU_LSB = 4;
    localparam int HYST_LO_LSB = 0;
    localparam int HYST_HI_LSB = 4;
    localparam int WIN_ONE_LSB = 0;
    localparam int EN_ONE_BIT = 3;
    localparam int WIN_TWO_LSB = 4;
    localparam int EN_TWO_BIT = 7;

    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] STEP_MS = 10'h032;
    localparam logic [4:0] DUTY_FULL = 5'h10;
    localparam logic [4:0] DUTY_OFF = 5'h00;
    localparam int FILT_SHIFT = 4;

    // Smoothing windows in tenths of a second, per code
    localparam logic [6:0] WIN_TENTHS [8] = '{7'h76, 7'h46, 7'h2C, 7'h1E,
                                             7'h10, 7'h08, 7'h06, 7'h04};

    typedef enum logic [1:0] {
        RAMP_HOLD = 2'b00,
        RAMP_UP = 2'b01,
        RAMP_DOWN = 2'b10
    } tfs_ramp_state_type;

    function automatic logic [9:0] step_delay_ms(input logic [3:0] code);
        return 10'(code) * STEP_MS;
    endfunction : step_delay_ms

    // One filter update per sixteenth of the window
    function automatic logic [9:0] slot_ms(input logic [2:0] code);
        logic [13:0] ms;
        ms = 14'(WIN_TENTHS[code]) * 14'h0064;
        return ms[13:4];
    endfunction : slot_ms

endpackage : tfs_pkg

// ==== inc/tfs_ramp_if.sv ====
// Purpose: Carrier between the register bank and one ramp unit
// Assumes: Same clock on both sides
// Notes: Duty is in sixteenths, 16 meaning fully on
`timescale 1ns/1ps
interface tfs_ramp_if;
    logic msTick;
    logic [3:0] stepCode;
    logic hotRequest;
    logic [4:0] duty;
    modport ctrl (output msTick, output stepCode, output hotRequest, input duty);
    modport ramp (input msTick, input stepCode, input hotRequest, output duty);
endinterface : tfs_ramp_if

// ==== verilog/tfs_ramp.sv ====
// Purpose: Ramped duty for one overtemperature line
// Assumes: One-cycle millisecond tick from the register bank
// Notes: Direction is re-decided every cycle, so a dropped request turns at once
`timescale 1ns/1ps
module tfs_ramp
    import tfs_pkg::*;
(
    input logic core_clk,
    input logic reset,
    input logic clkEnable,
    tfs_ramp_if.ramp ctl
);

    logic [4:0] duty_q;
    logic [9:0] msCount_q;
    logic [4:0] target;
    logic [9:0] delayMs;
    logic immediate;
    logic stepDue;
    tfs_ramp_state_type rampState;

    assign target = ctl.hotRequest ? DUTY_FULL : DUTY_OFF;
    assign delayMs = step_delay_ms(ctl.stepCode);
    assign immediate = (ctl.stepCode == 4'h0);
    assign stepDue = ctl.msTick && (msCount_q == delayMs - 10'h001);
    assign rampState = (duty_q < target) ? RAMP_UP :
                       (duty_q > target) ? RAMP_DOWN : RAMP_HOLD;
    assign ctl.duty = duty_q;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            duty_q <= DUTY_OFF;
            msCount_q <= 10'h000;
        end else if (clkEnable) begin
            if (immediate) begin
                duty_q <= target;
                msCount_q <= 10'h000;
            end else begin
                case (rampState)
                    RAMP_UP: begin
                        if (stepDue) duty_q <= duty_q + 5'h01;
                    end
                    RAMP_DOWN: begin
                        if (stepDue) duty_q <= duty_q - 5'h01;
                    end
                    default: begin
                        duty_q <= duty_q;
                    end
                endcase
                if (rampState == RAMP_HOLD || stepDue) msCount_q <= 10'h000;
                else if (ctl.msTick) msCount_q <= msCount_q + 10'h001;
            end
        end
    end

    a_ramp_duty_bound: assert property (@(posedge core_clk) disable iff (reset)
        duty_q <= DUTY_FULL)
        else $error("ramp duty above full scale");

endmodule : tfs_ramp

// ==== verilog/tfs_setup_regs.sv ====
// Purpose: Thermal and fan setup registers with ramp, boost and smoothing logic
// Assumes: Byte register port driven by the serial management front end
// Notes: Temperatures are unsigned whole degrees from the converter averager
`timescale 1ns/1ps

module tfs_setup_regs
    import tfs_pkg::*;
#(
    parameter int unsigned MS_TICK_CYCLES = MS_CYCLES
) (
    input logic core_clk,
    input logic reset,
    input logic clkEnable,
    input logic [7:0] regAddr,
    input logic [7:0] regWrData,
    input logic regWrEn,
    input logic regRdEn,
    output logic [7:0] regRdData,
    input logic [3:0][7:0] zoneTemp,
    input logic sampleValid,
    input logic [3:0][7:0] boostTemp,
    input logic [1:0] limitFilterSelect,
    input logic [1:0] fanFilterSelect,
    input logic regulatorHotRequest,
    input logic cpuHotRequest,
    output logic [5:0] lowThresholdSelect,
    output logic [4:0] regulatorHotDuty,
    output logic [4:0] cpuHotDuty,
    output logic [3:0] boostActive,
    output logic fanFullSpeed,
    output logic [1:0][7:0] limitTemp,
    output logic [1:0][7:0] fanTemp
);

    // Register storage
    logic [7:0] thresh_q;
    logic [7:0] ramp_q;
    logic [7:0] hystA_q;
    logic [7:0] hystB_q;
    logic [7:0] smooth_q;
    logic [7:0] rdData_q;

    // Millisecond tick
    logic [13:0] msCount_q;
    logic msTick_q;
    logic msWrap;

    // Smoothing state, zones one and two
    logic [11:0] filt_q [2];
    logic [9:0] slotCount_q [2];
    logic [7:0] sample_q [2];
    logic seeded_q;

    // Boost and routed temperatures
    logic [3:0] boost_q;
    logic fanFull_q;
    logic [1:0][7:0] limitTemp_q;
    logic [1:0][7:0] fanTemp_q;

    // Write strobes
    logic wrThresh;
    logic wrRamp;
    logic wrHystA;
    logic wrHystB;
    logic wrSmooth;
    logic [7:0] rdMux;

    // Decoded fields
    logic [3:0][3:0] hyst;
    logic [1:0][2:0] winCode;
    logic [1:0] smoothEn;
    logic [1:0] limitUseFilt;
    logic [1:0] fanUseFilt;
    logic [1:0][7:0] filtTemp;
    logic [3:0][7:0] boostInput;
    logic [3:0] overBoost;
    logic [3:0] belowRelease;
    logic [1:0] slotDue;

    tfs_ramp_if rampReg ();
    tfs_ramp_if rampCpu ();

    function automatic logic [11:0] filt_step(input logic [11:0] acc, input logic [7:0] sample);
        logic signed [13:0] diff;
        logic signed [13:0] sum;
        diff = $signed({2'b00, sample, 4'h0}) - $signed({2'b00, acc});
        sum = $signed({2'b00, acc}) + (diff >>> FILT_SHIFT);
        return sum[11:0];
    endfunction : filt_step

    assign wrThresh = regWrEn && (regAddr == ADDR_THRESH);
    assign wrRamp = regWrEn && (regAddr == ADDR_RAMP);
    assign wrHystA = regWrEn && (regAddr == ADDR_HYST_A);
    assign wrHystB = regWrEn && (regAddr == ADDR_HYST_B);
    assign wrSmooth = regWrEn && (regAddr == ADDR_SMOOTH);

    // Filtered registers are read-only; unmapped reads return zero
    assign rdMux = (regAddr == ADDR_THRESH) ? thresh_q :
                   (regAddr == ADDR_RAMP) ? ramp_q :
                   (regAddr == ADDR_HYST_A) ? hystA_q :
                   (regAddr == ADDR_HYST_B) ? hystB_q :
                   (regAddr == ADDR_SMOOTH) ? smooth_q :
                   (regAddr == ADDR_FILT_ONE) ? filtTemp[0] :
                   (regAddr == ADDR_FILT_TWO) ? filtTemp[1] : READ_UNMAPPED;

    assign hyst[0] = hystA_q[HYST_LO_LSB +: 4];
    assign hyst[1] = hystA_q[HYST_HI_LSB +: 4];
    assign hyst[2] = hystB_q[HYST_LO_LSB +: 4];
    assign hyst[3] = hystB_q[HYST_HI_LSB +: 4];
    assign winCode[0] = smooth_q[WIN_ONE_LSB +: 3];
    assign winCode[1] = smooth_q[WIN_TWO_LSB +: 3];
    assign smoothEn = {smooth_q[EN_TWO_BIT], smooth_q[EN_ONE_BIT]};
    // Select bits only behave when the enables are clear; ORing keeps either path live
    assign limitUseFilt = smoothEn | limitFilterSelect;
    assign fanUseFilt = smoothEn | fanFilterSelect;
    assign filtTemp[0] = filt_q[0][11:4];
    assign filtTemp[1] = filt_q[1][11:4];

    assign boostInput[0] = fanUseFilt[0] ? filtTemp[0] : zoneTemp[0];
    assign boostInput[1] = fanUseFilt[1] ? filtTemp[1] : zoneTemp[1];
    assign boostInput[2] = zoneTemp[2];
    assign boostInput[3] = zoneTemp[3];

    assign msWrap = (msCount_q == 14'(MS_TICK_CYCLES - 1));
    assign slotDue[0] = msTick_q && (slotCount_q[0] >= slot_ms(winCode[0]) - 10'h001);
    assign slotDue[1] = msTick_q && (slotCount_q[1] >= slot_ms(winCode[1]) - 10'h001);

    genvar z;
    generate
        for (z = 0; z < 4; z++) begin : g_zone
            assign overBoost[z] = boostInput[z] > boostTemp[z];
            // Nine bits so hysteresis on a hot reading cannot wrap
            assign belowRelease[z] = ({1'b0, boostInput[z]} + {5'h00, hyst[z]})
                                     <= {1'b0, boostTemp[z]};
        end
    endgenerate

    assign rampReg.msTick = msTick_q;
    assign rampReg.stepCode = ramp_q[RAMP_REG_LSB +: 4];
    assign rampReg.hotRequest = regulatorHotRequest;
    assign rampCpu.msTick = msTick_q;
    assign rampCpu.stepCode = ramp_q[RAMP_CPU_LSB +: 4];
    assign rampCpu.hotRequest = cpuHotRequest;

    tfs_ramp u_rampReg (
        .core_clk(core_clk),
        .reset(reset),
        .clkEnable(clkEnable),
        .ctl(rampReg.ramp)
    );

    tfs_ramp u_rampCpu (
        .core_clk(core_clk),
        .reset(reset),
        .clkEnable(clkEnable),
        .ctl(rampCpu.ramp)
    );

    always_ff @(posedge core_clk) begin
        if (reset) begin
            thresh_q <= RST_THRESH;
            ramp_q <= RST_RAMP;
            hystA_q <= RST_HYST;
            hystB_q <= RST_HYST;
            smooth_q <= RST_SMOOTH;
            rdData_q <= READ_UNMAPPED;
        end else if (clkEnable) begin
            if (wrThresh) thresh_q <= regWrData & THRESH_WR_MASK;
            if (wrRamp) ramp_q <= regWrData;
            if (wrHystA) hystA_q <= regWrData;
            if (wrHystB) hystB_q <= regWrData;
            if (wrSmooth) smooth_q <= regWrData;
            if (regRdEn) rdData_q <= rdMux;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            msCount_q <= 14'h0000;
            msTick_q <= 1'b0;
        end else if (clkEnable) begin
            msCount_q <= msWrap ? 14'h0000 : msCount_q + 14'h0001;
            msTick_q <= msWrap;
        end
    end

    // Smoothing runs on the averaged converter samples, after that stage
    always_ff @(posedge core_clk) begin
        if (reset) begin
            for (int i = 0; i < 2; i++) begin
                filt_q[i] <= 12'h000;
                slotCount_q[i] <= 10'h000;
                sample_q[i] <= 8'h00;
            end
            seeded_q <= 1'b0;
        end else if (clkEnable) begin
            if (sampleValid) begin
                sample_q[0] <= zoneTemp[0];
                sample_q[1] <= zoneTemp[1];
            end
            // First sample seeds the filter so it does not crawl up from zero
            if (sampleValid && !seeded_q) begin
                filt_q[0] <= {zoneTemp[0], 4'h0};
                filt_q[1] <= {zoneTemp[1], 4'h0};
                seeded_q <= 1'b1;
            end else if (seeded_q) begin
                for (int i = 0; i < 2; i++) begin
                    if (slotDue[i]) filt_q[i] <= filt_step(filt_q[i], sample_q[i]);
                end
            end
            for (int i = 0; i < 2; i++) begin
                if (slotDue[i]) slotCount_q[i] <= 10'h000;
                else if (msTick_q) slotCount_q[i] <= slotCount_q[i] + 10'h001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            boost_q <= 4'h0;
            fanFull_q <= 1'b0;
            limitTemp_q <= '0;
            fanTemp_q <= '0;
        end else if (clkEnable) begin
            for (int i = 0; i < 4; i++) begin
                if (overBoost[i]) boost_q[i] <= 1'b1;
                else if (belowRelease[i]) boost_q[i] <= 1'b0;
            end
            fanFull_q <= |(overBoost | (boost_q & ~belowRelease));
            for (int i = 0; i < 2; i++) begin
                limitTemp_q[i] <= limitUseFilt[i] ? filtTemp[i] : zoneTemp[i];
                fanTemp_q[i] <= boostInput[i];
            end
        end
    end

    assign regRdData = rdData_q;
    assign lowThresholdSelect = {thresh_q[7:4], thresh_q[1:0]};
    assign regulatorHotDuty = rampReg.duty;
    assign cpuHotDuty = rampCpu.duty;
    assign boostActive = boost_q;
    assign fanFullSpeed = fanFull_q;
    assign limitTemp = limitTemp_q;
    assign fanTemp = fanTemp_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);

    a_thresh_reserved_zero: assert property (thresh_q[3:2] == 2'b00)
        else $error("reserved threshold bits not zero");

    a_thresh_write_takes: assert property (clkEnable && wrThresh |=>
        thresh_q == ($past(regWrData) & THRESH_WR_MASK))
        else $error("threshold write not stored");

    a_reg_instant_full: assert property (clkEnable && ramp_q[3:0] == 4'h0
        && regulatorHotRequest |=> regulatorHotDuty == DUTY_FULL)
        else $error("regulator duty not immediately full");

    a_cpu_instant_full: assert property (clkEnable && ramp_q[7:4] == 4'h0
        && cpuHotRequest |=> cpuHotDuty == DUTY_FULL)
        else $error("cpu duty not immediately full");

    a_cpu_step_one: assert property (ramp_q[7:4] != 4'h0 && $past(ramp_q[7:4]) != 4'h0
        |-> cpuHotDuty == $past(cpuHotDuty) || cpuHotDuty == $past(cpuHotDuty) + 5'h01
        || cpuHotDuty + 5'h01 == $past(cpuHotDuty))
        else $error("cpu duty stepped by more than one");

    // Tick holds while frozen, so its drop is only checked on enabled cycles
    a_tick_period: assert property (clkEnable && msWrap |=> msTick_q)
        else $error("millisecond tick wrong");

    a_tick_single: assert property (clkEnable && msTick_q |=> !msTick_q)
        else $error("millisecond tick longer than one cycle");

    a_hyst_reset_value: assert property ($fell(reset) |->
        hystA_q == RST_HYST && hystB_q == RST_HYST)
        else $error("hysteresis reset value wrong");

    a_boost_held_on: assert property (clkEnable && boost_q[2] && !belowRelease[2]
        |=> boost_q[2] && fanFull_q)
        else $error("boost released too early");

    a_boost_release_done: assert property (clkEnable && !overBoost[2]
        && belowRelease[2] |=> !boost_q[2])
        else $error("boost not released");

    a_filter_drives_fan: assert property (clkEnable && smooth_q[EN_ONE_BIT]
        |=> fanTemp[0] == $past(filtTemp[0]))
        else $error("fan path ignores filtered value");

    a_filter_reg_read: assert property (clkEnable && regRdEn && regAddr == ADDR_FILT_ONE
        |=> regRdData == $past(filtTemp[0]))
        else $error("filtered register read wrong");

    a_raw_limit_path: assert property (clkEnable && !limitUseFilt[0]
        |=> limitTemp[0] == $past(zoneTemp[0]))
        else $error("limit path not raw");

    a_reg_step_one: assert property (ramp_q[3:0] != 4'h0 && $past(ramp_q[3:0]) != 4'h0
        |-> regulatorHotDuty == $past(regulatorHotDuty)
        || regulatorHotDuty == $past(regulatorHotDuty) + 5'h01
        || regulatorHotDuty + 5'h01 == $past(regulatorHotDuty))
        else $error("regulator duty stepped by more than one");

    a_fan_full_over: assert property (clkEnable && (|overBoost)
        |=> fanFull_q && (boost_q & $past(overBoost)) == $past(overBoost))
        else $error("boost not raised over its temperature");

    a_limit_filter_two: assert property (clkEnable && smooth_q[EN_TWO_BIT]
        |=> limitTemp[1] == $past(filtTemp[1]))
        else $error("limit path ignores filtered value");

    a_hyst_write_takes: assert property (clkEnable && wrHystA |=>
        hystA_q == $past(regWrData))
        else $error("hysteresis write not stored");

    c_reg_ramp_full: cover property (regulatorHotDuty == DUTY_FULL && ramp_q[3:0] != 4'h0);
    c_boost_hold: cover property (boost_q[0] && !overBoost[0]);
    c_filter_used: cover property (smooth_q[EN_TWO_BIT] && slotDue[1]);
    c_cpu_ramp_step: cover property (cpuHotDuty == 5'h01 && ramp_q[7:4] != 4'h0);
    c_boost_zone_four: cover property (boost_q[3] && !overBoost[3]);

endmodule : tfs_setup_regs

// ==== dv/tfs_setup_regs_bench.sv ====
// Purpose: Self-checking bench for the thermal and fan setup registers
// Assumes: Short ms tick so ramp and filter timing fit a short run
// Notes: Random data from a 16-bit LFSR, fixed start value
`timescale 1ns/1ps
module tfs_setup_regs_bench
    import tfs_pkg::*;
;
    localparam int TICK = 4;
    logic core_clk = 1'b0;
    logic reset, clkEnable, regWrEn, regRdEn, sampleValid;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [3:0][7:0] zoneTemp, boostTemp;
    logic [1:0] limitFilterSelect, fanFilterSelect;
    logic regulatorHotRequest, cpuHotRequest, fanFullSpeed;
    logic [5:0] lowThresholdSelect;
    logic [4:0] regulatorHotDuty, cpuHotDuty;
    logic [3:0] boostActive;
    logic [1:0][7:0] limitTemp, fanTemp;
    int miscompares = 0;
    int nChecks = 0;
    logic [15:0] lfsr = 16'hF8CB;

    tfs_setup_regs #(.MS_TICK_CYCLES(TICK)) tfs_setup_regs_i (.core_clk(core_clk),
        .reset(reset), .clkEnable(clkEnable), .regAddr(regAddr), .regWrData(regWrData),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .zoneTemp(zoneTemp),
        .sampleValid(sampleValid), .boostTemp(boostTemp),
        .limitFilterSelect(limitFilterSelect), .fanFilterSelect(fanFilterSelect),
        .regulatorHotRequest(regulatorHotRequest), .cpuHotRequest(cpuHotRequest),
        .lowThresholdSelect(lowThresholdSelect), .regulatorHotDuty(regulatorHotDuty),
        .cpuHotDuty(cpuHotDuty), .boostActive(boostActive), .fanFullSpeed(fanFullSpeed),
        .limitTemp(limitTemp), .fanTemp(fanTemp));

    always #50 core_clk = ~core_clk;

    function automatic logic [15:0] lfsrNext(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsrNext

    // Reserved threshold bits read zero, unmapped space reads zero
    function automatic logic [7:0] expRead(input logic [7:0] a, input logic [7:0] d);
        return (a >= 8'hBE && a <= 8'hC2) ? ((a == 8'hBE) ? (d & 8'hF3) : d) : 8'h00;
    endfunction : expRead

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chkTrue(input logic c, input string what);
        chk({7'h00, c}, 8'h01, what);
    endtask : chkTrue

    task automatic cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask : cycles

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge core_clk);
        regWrEn <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge core_clk);
        regRdEn <= 1'b0;
        @(posedge core_clk);
        #1 d = regRdData;
    endtask : rd

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp, what);
    endtask : rdChk

    task automatic pulse(input logic [7:0] t0, input logic [7:0] t1);
        @(posedge core_clk);
        zoneTemp[0] <= t0;
        zoneTemp[1] <= t1;
        sampleValid <= 1'b1;
        @(posedge core_clk);
        sampleValid <= 1'b0;
    endtask : pulse

    task automatic conclude();
        $display("Checks %0d, miscompares %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude

    // Whole run is about a thousand cycles
    initial begin
        cycles(20000);
        miscompares++;
        $display("ERROR at %0t: watchdog expired", $time);
        conclude();
    end

    initial begin
        logic [7:0] a, d, h, f, lt;
        int nr, nc;
        reset = 1'b1;
        clkEnable = 1'b1;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        sampleValid = 1'b0;
        zoneTemp = {4{8'd20}};
        boostTemp = {4{8'h50}};
        limitFilterSelect = 2'b00;
        fanFilterSelect = 2'b00;
        regulatorHotRequest = 1'b0;
        cpuHotRequest = 1'b0;
        cycles(12);
        reset <= 1'b0;
        rdChk(ADDR_THRESH, 8'h00, "threshold reset");
        rdChk(ADDR_RAMP, 8'h00, "ramp reset");
        rdChk(ADDR_HYST_A, 8'h44, "hyst A reset");
        rdChk(ADDR_HYST_B, 8'h44, "hyst B reset");
        rdChk(ADDR_SMOOTH, 8'h00, "smoothing reset");
        $display("Test reset values done");

        // Fastest window set early so the slot counter starts small
        wr(ADDR_SMOOTH, 8'h07);
        pulse(8'd30, 8'd30);
        rdChk(ADDR_FILT_ONE, 8'd30, "seeded filter");
        pulse(8'd90, 8'd90);
        cycles(2);
        #1 chk(limitTemp[0], 8'd90, "raw limit path");
        wr(ADDR_SMOOTH, 8'h0F);
        cycles(4 * 25 * TICK);
        @(negedge core_clk);
        lt = limitTemp[0];
        chkTrue(lt > 8'd30 && lt < 8'd90, "filtered limit path");
        chk(fanTemp[0], lt, "filtered fan path");
        chk(limitTemp[1], 8'd90, "zone two limit raw");
        chk(fanTemp[1], 8'd90, "zone two fan raw");
        rd(ADDR_FILT_ONE, f);
        chkTrue(f >= lt && f < 8'd90, "filtered register");
        // Select bits only with both enables clear
        wr(ADDR_SMOOTH, 8'h07);
        fanFilterSelect <= 2'b10;
        limitFilterSelect <= 2'b01;
        cycles(2);
        #1 chkTrue(fanTemp[1] >= 8'd30 && fanTemp[1] < 8'd90, "zone two fan selected");
        chkTrue(limitTemp[0] >= f && limitTemp[0] < 8'd90, "zone one limit selected");
        chk(fanTemp[0], 8'd90, "zone one fan raw");
        chk(limitTemp[1], 8'd90, "zone two limit unselected");
        @(posedge core_clk);
        fanFilterSelect <= 2'b00;
        limitFilterSelect <= 2'b00;
        zoneTemp <= {4{8'd20}};
        wr(ADDR_SMOOTH, 8'h00);
        $display("Test smoothing done");

        lfsr = lfsrNext(lfsr);
        wr(ADDR_HYST_A, {lfsr[7:4], 4'hF});
        wr(ADDR_HYST_B, lfsr[15:8]);
        #1 chk({7'h00, fanFullSpeed}, 8'h00, "full speed idle");
        for (int z = 0; z < 4; z++) begin
            h = (z == 0) ? 8'h0F : (z == 1) ? 8'(lfsr[7:4]) :
                (z == 2) ? 8'(lfsr[11:8]) : 8'(lfsr[15:12]);
            @(posedge core_clk);
            zoneTemp[z] <= 8'h51;
            cycles(2);
            #1 chk({7'h00, boostActive[z]}, 8'h01, "boost set");
            chk({7'h00, fanFullSpeed}, 8'h01, "full speed");
            @(posedge core_clk);
            zoneTemp[z] <= 8'h51 - h;
            cycles(3);
            #1 chk({7'h00, boostActive[z]}, 8'h01, "boost held");
            @(posedge core_clk);
            zoneTemp[z] <= 8'h50 - h;
            cycles(2);
            #1 chk({7'h00, boostActive[z]}, 8'h00, "boost release");
            @(posedge core_clk);
            zoneTemp[z] <= 8'd20;
        end
        cycles(2);
        #1 chk({7'h00, fanFullSpeed}, 8'h00, "full speed off");
        $display("Test boost hysteresis done");

        // Regulator code 1, cpu code 2: first step at 50 and 100 ms
        wr(ADDR_RAMP, 8'h21);
        regulatorHotRequest <= 1'b1;
        cpuHotRequest <= 1'b1;
        nr = 0;
        nc = 0;
        for (int t = 1; t <= 1000 && nc == 0; t++) begin
            @(posedge core_clk);
            #1;
            if (nr == 0 && regulatorHotDuty !== 5'h00) nr = t;
            if (cpuHotDuty !== 5'h00) nc = t;
        end
        chkTrue(nr >= 48 * TICK && nr <= 52 * TICK, "regulator step time");
        chkTrue(nc >= 98 * TICK && nc <= 102 * TICK, "cpu step time");
        chk(8'(cpuHotDuty), 8'h01, "cpu single step");
        wr(ADDR_RAMP, 8'h00);
        cycles(2);
        #1 chk(8'(regulatorHotDuty), 8'h10, "regulator full");
        chk(8'(cpuHotDuty), 8'h10, "cpu full");
        @(posedge core_clk);
        regulatorHotRequest <= 1'b0;
        cpuHotRequest <= 1'b0;
        cycles(2);
        #1 chk(8'(regulatorHotDuty), 8'h00, "regulator off");
        chk(8'(cpuHotDuty), 8'h00, "cpu off");
        $display("Test ramp done");

        for (int i = 0; i < 6; i++) begin
            for (int k = 0; k < 6; k++) begin
                a = (k == 5) ? 8'hC3 : 8'hBE + 8'(k);
                lfsr = lfsrNext(lfsr);
                d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : lfsr[7:0];
                wr(a, d);
                rdChk(a, expRead(a, d), "readback");
                if (a == ADDR_THRESH) begin
                    chk({2'b00, lowThresholdSelect}, {2'b00, d[7:4], d[1:0]}, "pins");
                end
            end
        end
        wr(ADDR_RAMP, 8'h5A);
        clkEnable <= 1'b0;
        wr(ADDR_RAMP, 8'hA5);
        clkEnable <= 1'b1;
        rdChk(ADDR_RAMP, 8'h5A, "frozen write");
        $display("Test register access done");
        conclude();
    end
endmodule : tfs_setup_regs_bench
